/* File: design/dcc_channel.sv */
// one dma channel: apb registers, flow control, arbiter lock, pointer update, interrupt
`timescale 1ns/10ps
module dcc_channel
   import dcc_pkg::*;
#(
   parameter int FC_DEVICES = FCDEV_COUNT
)
(
   // clock and reset
   input  wire logic                  clk,
   input  wire logic                  rst_b,
   // apb slave
   input  wire logic                  psel,
   input  wire logic                  penable,
   input  wire logic                  pwrite,
   input  wire logic [7:0]            paddr,
   input  wire logic [31:0]           pwdata,
   output logic                       pready,
   output logic [31:0]                prdata,
   output logic                       pslverr,
   // hardware flow control
   input  wire logic [FC_DEVICES-1:0] fcReq,
   input  wire logic [FC_DEVICES-1:0] fcTerm,
   output logic                       fcAck,
   // channel arbiter
   output logic                       arbReq,
   output logic                       arbLock,
   input  wire logic                  arbGrant,
   // internal bus
   output logic                       busReq,
   output logic                       busWrite,
   output logic [31:0]                busAddr,
   output logic [2:0]                 busSize,
   output logic [31:0]                busWdata,
   input  wire logic                  busAck,
   input  wire logic [31:0]           busRdata,
   // interrupt
   output logic                       irq
);
   import dcc_pkg::*;

   // number of master indices that the select field can name
   localparam int FC_SPAN = 1 << FCDEV_W;

   typedef struct packed {
      // transfer machine
      dcc_state_t      st;
      logic            active;
      // address pointers
      logic [31:0]     memPtr;
      logic [31:0]     memEnd;
      logic [31:0]     devPtr;
      // control register fields
      logic            run;
      logic            dir;
      logic [6:0]      fcDev;
      logic            incMem;
      logic            incDev;
      logic            lock;
      logic            hwfcOff;
      logic [2:0]      size;
      logic            fwStart;
      logic            abort;
      // transfer bookkeeping
      logic            fwMode;
      logic            held;
      logic            arb;
      logic [31:0]     data;
      // events, apb answer and outputs
      logic [EV_W-1:0] stat;
      logic [EV_W-1:0] mask;
      logic            ready;
      logic [31:0]     rdata;
      logic            ack;
      logic            irq;
   } dcc_reg_t;
   dcc_reg_t s_q, s_d;

   // request path to the packet port
   dcc_bus_if bus ();

   // synchroniser stages and decoded helpers
   logic [FC_DEVICES-1:0] req1_q, req2_q, term1_q, term2_q;
   logic [FC_SPAN-1:0]    reqWide;
   logic [FC_SPAN-1:0]    termWide;
   logic                  hwReq;
   logic                  hwTerm;
   logic [31:0]           ctrlWord;
   logic                  apbAcc;
   logic                  rdStat;
   logic [EV_W-1:0]       ev;
   logic [31:0]           step;

   // two-flop synchronisers for the flow-control request and terminate lines
   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         req1_q  <= '0;
         req2_q  <= '0;
         term1_q <= '0;
         term2_q <= '0;
      end
      else
      begin
         req1_q  <= fcReq;
         req2_q  <= req1_q;
         term1_q <= fcTerm;
         term2_q <= term1_q;
      end
   end

   // pad the master lines to every selectable index; an unwired index reads idle
   assign reqWide  = FC_SPAN'(req2_q);
   assign termWide = FC_SPAN'(term2_q);

   // selected master request, masked by bypass, run and activate
   assign hwReq  = reqWide[s_q.fcDev] && !s_q.hwfcOff && s_q.run && s_q.active;
   assign hwTerm = termWide[s_q.fcDev] && !s_q.hwfcOff;

   // readback of the control word; reserved bits stay zero
   always_comb
   begin
      ctrlWord                                = '0;
      ctrlWord[RUN_BIT]                       = s_q.run;
      ctrlWord[REQUEST_BIT]                   = hwReq;
      ctrlWord[DONE_BIT]                      = s_q.run && (s_q.st == ST_IDLE);
      ctrlWord[BUSY_BIT]                      = (s_q.st != ST_IDLE);
      ctrlWord[DIR_BIT]                       = s_q.dir;
      ctrlWord[FCDEV_LSB +: FCDEV_W]          = s_q.fcDev;
      ctrlWord[INC_MEM_BIT]                   = s_q.incMem;
      ctrlWord[INC_DEV_BIT]                   = s_q.incDev;
      ctrlWord[LOCK_BIT]                      = s_q.lock;
      ctrlWord[HWFC_OFF_BIT]                  = s_q.hwfcOff;
      ctrlWord[SIZE_LSB +: SIZE_W]            = s_q.size;
      ctrlWord[FWSTART_BIT]                   = s_q.fwStart;
      ctrlWord[ABORT_BIT]                     = s_q.abort;
   end

   // access decode and packet step in bytes
   assign apbAcc = psel && penable && !s_q.ready;
   assign rdStat = apbAcc && !pwrite && (paddr == INT_STAT_OFS);
   assign step   = {29'h0000_0000, s_q.size};

   // main next-state logic: registers, transfer machine, events
   always_comb
   begin
      s_d       = s_q;
      s_d.ready = 1'b0;
      s_d.ack   = 1'b0;
      ev        = '0;
      // packet port request idles unless a bus state drives it
      bus.req   = 1'b0;
      bus.wr    = 1'b0;
      bus.addr  = '0;
      bus.size  = s_q.size;
      bus.wdata = s_q.data;

      // apb access phase answered one cycle later, unmapped reads zero
      if (apbAcc)
      begin
         s_d.ready = 1'b1;
         s_d.rdata = '0;
         // writes store only the defined fields; reserved bits are dropped
         if (pwrite)
         begin
            unique case (paddr)
               ACTIVATE_OFS:  s_d.active = pwdata[0];
               MEM_START_OFS: s_d.memPtr = pwdata;
               MEM_END_OFS:   s_d.memEnd = pwdata;
               DEV_ADDR_OFS:  s_d.devPtr = pwdata;
               CONTROL_OFS:
               begin
                  s_d.run     = pwdata[RUN_BIT];
                  s_d.dir     = pwdata[DIR_BIT];
                  s_d.fcDev   = pwdata[FCDEV_LSB +: FCDEV_W];
                  s_d.incMem  = pwdata[INC_MEM_BIT];
                  s_d.incDev  = pwdata[INC_DEV_BIT];
                  s_d.lock    = pwdata[LOCK_BIT];
                  s_d.hwfcOff = pwdata[HWFC_OFF_BIT];
                  s_d.size    = pwdata[SIZE_LSB +: SIZE_W];
                  s_d.fwStart = pwdata[FWSTART_BIT];
                  s_d.abort   = pwdata[ABORT_BIT];
               end
               INT_MASK_OFS:  s_d.mask = pwdata[EV_W-1:0];
               default:       ;
            endcase
         end
         else
         begin
            unique case (paddr)
               ACTIVATE_OFS:  s_d.rdata = {31'h0000_0000, s_q.active};
               MEM_START_OFS: s_d.rdata = s_q.memPtr;
               MEM_END_OFS:   s_d.rdata = s_q.memEnd;
               DEV_ADDR_OFS:  s_d.rdata = s_q.devPtr;
               CONTROL_OFS:   s_d.rdata = ctrlWord;
               INT_STAT_OFS:  s_d.rdata = {29'h0000_0000, s_q.stat};
               INT_MASK_OFS:  s_d.rdata = {29'h0000_0000, s_q.mask};
               default:       s_d.rdata = '0;
            endcase
         end
      end

      // transfer state machine
      unique case (s_q.st)
         ST_IDLE:
         begin
            if (s_q.active && !s_q.abort && s_q.fwStart && s_q.hwfcOff)
            begin
               s_d.st      = ST_ARB;
               s_d.fwMode  = 1'b1;
               s_d.fwStart = 1'b0;
            end
            else if (s_q.active && !s_q.abort && hwReq)
            begin
               s_d.st     = ST_ARB;
               s_d.fwMode = 1'b0;
            end
         end
         ST_ARB:
         begin
            if (arbGrant || s_q.held)
            begin
               s_d.st   = ST_READ;
               s_d.held = s_q.lock;
            end
         end
         ST_READ:
         begin
            bus.req  = 1'b1;
            bus.addr = s_q.dir ? s_q.memPtr : s_q.devPtr;
            if (bus.ack)
            begin
               s_d.data = bus.rdata;
               s_d.st   = ST_WRITE;
            end
         end
         ST_WRITE:
         begin
            bus.req  = 1'b1;
            bus.wr   = 1'b1;
            bus.addr = s_q.dir ? s_q.devPtr : s_q.memPtr;
            if (bus.ack)
            begin
               s_d.st  = ST_NEXT;
               s_d.ack = !s_q.fwMode;
               // pointers advance once the write lands
               if (s_q.incMem)
                  s_d.memPtr = s_q.memPtr + step;
               if (s_q.incDev)
                  s_d.devPtr = s_q.devPtr + step;
            end
         end
         ST_NEXT:
         begin
            // end check after every packet: done, terminate, continue or idle
            if (s_q.incMem && (s_q.memPtr == s_q.memEnd))
            begin
               s_d.st   = ST_IDLE;
               s_d.held = 1'b0;
               ev[EV_DONE_BIT] = 1'b1;
            end
            else if (!s_q.fwMode && hwTerm)
            begin
               s_d.st   = ST_IDLE;
               s_d.held = 1'b0;
               ev[EV_TERM_BIT] = 1'b1;
            end
            else if (s_q.fwMode || hwReq)
               s_d.st = s_q.held ? ST_READ : ST_ARB;
            else
            begin
               s_d.st   = ST_IDLE;
               s_d.held = 1'b0;
            end
         end
         default: s_d.st = ST_IDLE;
      endcase

      // abort wins over everything except a bus ack in the same cycle; a packet in flight is dropped
      if (s_q.abort && (s_q.st != ST_IDLE) && !bus.ack)
      begin
         s_d.st   = ST_IDLE;
         s_d.held = 1'b0;
         s_d.ack  = 1'b0;
         ev[EV_ABORT_BIT] = 1'b1;
      end

      // sticky status: read clears, a new event wins over the clear
      s_d.stat = (rdStat ? '0 : s_q.stat) | ev;
      s_d.irq  = |(s_d.stat & s_d.mask);
      // arbiter request registered from the next state
      s_d.arb  = (s_d.st == ST_ARB);
   end

   // state register; every field clears on reset
   always_ff @(posedge clk)
   begin
      if (!rst_b)
         s_q <= '0;
      else
         s_q <= s_d;
   end

   // packet access port
   dcc_bus_port u_port (
      .clk      (clk),
      .rst_b    (rst_b),
      .cmd      (bus.port),
      .busReq   (busReq),
      .busWrite (busWrite),
      .busAddr  (busAddr),
      .busSize  (busSize),
      .busWdata (busWdata),
      .busAck   (busAck),
      .busRdata (busRdata)
   );

   // outputs straight from the state registers; pslverr is tied low
   assign pready  = s_q.ready;
   assign prdata  = s_q.rdata;
   assign pslverr = 1'b0;
   assign fcAck   = s_q.ack;
   assign arbReq  = s_q.arb;
   assign arbLock = s_q.held;
   assign irq     = s_q.irq;
endmodule // dcc_channel

/* File: design/dcc_pkg.sv */
// package of register map, field positions and types for the dma channel control block
package dcc_pkg;
   // register byte offsets
   localparam logic [7:0] ACTIVATE_OFS  = 8'h00;
   localparam logic [7:0] MEM_START_OFS = 8'h04;
   localparam logic [7:0] MEM_END_OFS   = 8'h08;
   localparam logic [7:0] DEV_ADDR_OFS  = 8'h0c;
   localparam logic [7:0] CONTROL_OFS   = 8'h10;
   localparam logic [7:0] INT_STAT_OFS  = 8'h14;
   localparam logic [7:0] INT_MASK_OFS  = 8'h18;
   // control register field positions
   localparam int RUN_BIT      = 0;
   localparam int REQUEST_BIT  = 1;
   localparam int DONE_BIT     = 2;
   localparam int BUSY_BIT     = 5;
   localparam int DIR_BIT      = 8;
   localparam int FCDEV_LSB    = 9;
   localparam int FCDEV_W      = 7;
   localparam int INC_MEM_BIT  = 16;
   localparam int INC_DEV_BIT  = 17;
   localparam int LOCK_BIT     = 18;
   localparam int HWFC_OFF_BIT = 19;
   localparam int SIZE_LSB     = 20;
   localparam int SIZE_W       = 3;
   localparam int FWSTART_BIT  = 24;
   localparam int ABORT_BIT    = 25;
   // interrupt status bit positions
   localparam int EV_DONE_BIT  = 0;
   localparam int EV_ABORT_BIT = 1;
   localparam int EV_TERM_BIT  = 2;
   localparam int EV_W         = 3;
   // reset value and default flow-control device count
   localparam logic [31:0] WORD_RST = 32'h0000_0000;
   localparam logic [7:0]  FCDEV_COUNT = 8'h10;
   // transfer state machine
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_ARB,
      ST_READ,
      ST_WRITE,
      ST_NEXT
   } dcc_state_t;
   // internal bus operation code
   typedef enum logic [1:0] {
      OP_NONE,
      OP_READ,
      OP_WRITE
   } dcc_op_t;
endpackage

/* File: design/dcc_bus_if.sv */
// interface between the channel control and its internal bus port
`timescale 1ns/10ps
interface dcc_bus_if;
   import dcc_pkg::*;
   logic        req;
   logic        wr;
   logic [31:0] addr;
   logic [2:0]  size;
   logic [31:0] wdata;
   logic        ack;
   logic [31:0] rdata;
   modport ctrl (output req, output wr, output addr, output size, output wdata,
                 input ack, input rdata);
   modport port (input req, input wr, input addr, input size, input wdata,
                 output ack, output rdata);
endinterface

/* File: design/dcc_bus_port.sv */
// registered internal bus master port: holds one packet access until acknowledged
`timescale 1ns/10ps
module dcc_bus_port
   import dcc_pkg::*;
(
   // clock and reset
   input  wire logic        clk,
   input  wire logic        rst_b,
   // request side
   dcc_bus_if.port          cmd,
   // internal bus
   output logic             busReq,
   output logic             busWrite,
   output logic [31:0]      busAddr,
   output logic [2:0]       busSize,
   output logic [31:0]      busWdata,
   input  wire logic        busAck,
   input  wire logic [31:0] busRdata
);
   typedef struct packed {
      logic        req;
      logic        wr;
      logic [31:0] addr;
      logic [2:0]  size;
      logic [31:0] wdata;
      logic        ack;
      logic [31:0] rdata;
   } dcc_port_t;
   dcc_port_t s_q, s_d;

   // accept a request, drive it until the bus acknowledges, return one ack pulse
   always_comb
   begin
      s_d     = s_q;
      s_d.ack = 1'b0;
      if (!s_q.req && cmd.req && !s_q.ack)
      begin
         s_d.req   = 1'b1;
         s_d.wr    = cmd.wr;
         s_d.addr  = cmd.addr;
         s_d.size  = cmd.size;
         s_d.wdata = cmd.wdata;
      end
      else if (s_q.req && busAck)
      begin
         s_d.req   = 1'b0;
         s_d.ack   = 1'b1;
         s_d.rdata = busRdata;
      end
   end

   // state register
   always_ff @(posedge clk)
   begin
      if (!rst_b)
         s_q <= '0;
      else
         s_q <= s_d;
   end

   assign busReq    = s_q.req;
   assign busWrite  = s_q.wr;
   assign busAddr   = s_q.addr;
   assign busSize   = s_q.size;
   assign busWdata  = s_q.wdata;
   assign cmd.ack   = s_q.ack;
   assign cmd.rdata = s_q.rdata;
endmodule // dcc_bus_port

/* File: bench/dcc_channel_checker.sv */
// assertion checker bound to the dma channel control block
`timescale 1ns/10ps
module dcc_channel_checker
   import dcc_pkg::*;
(
   // clock and reset
   input wire logic        clk,
   input wire logic        rst_b,
   // apb
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic        pready,
   input wire logic [31:0] prdata,
   // flow control and arbiter
   input wire logic        fcAck,
   input wire logic        arbReq,
   // internal bus
   input wire logic        busReq,
   input wire logic        busWrite,
   input wire logic [31:0] busAddr,
   input wire logic [2:0]  busSize,
   input wire logic        busAck,
   // interrupt
   input wire logic        irq
);
   import dcc_pkg::*;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);
   // steps of an apb access and of an abort
   sequence accessWait;
      psel && penable && !pready;
   endsequence
   sequence abortWrite;
      psel && penable && pwrite && paddr == CONTROL_OFS && pwdata[ABORT_BIT];
   endsequence
   sequence quiet4;
      (!busReq && !arbReq)[*4];
   endsequence
   // apb answer one cycle after the first access edge, for one cycle
   AST_PREADY_WAIT: assert property (accessWait |=> pready)
      else $error("pready not one cycle after access");
   AST_PREADY_PULSE: assert property (pready |=> !pready)
      else $error("pready longer than one cycle");
   // unmapped place reads zero
   AST_UNMAPPED_ZERO: assert property (
      pready && !$past(pwrite) && $past(paddr) == 8'h1C |-> prdata == 32'h0000_0000)
      else $error("unmapped read not zero");
   // outputs low through and after reset
   AST_RESET_QUIET: assert property (disable iff (1'b0)
      !rst_b |=> !busReq && !fcAck && !irq && !pready && !arbReq)
      else $error("output active after reset");
   // bus request held steady until acknowledged
   AST_BUS_HOLD: assert property (
      busReq && !busAck |=> busReq && $stable(busAddr) && $stable(busWrite))
      else $error("bus request dropped or changed before ack");
   AST_FCACK_PULSE: assert property (fcAck |=> !fcAck)
      else $error("flow-control ack longer than one cycle");
   AST_SIZE_LEGAL: assert property (
      busReq |-> busSize inside {3'd1, 3'd2, 3'd4})
      else $error("illegal packet size on bus");
   // abort stops the channel within the pending access
   AST_ABORT_STOP: assert property (abortWrite |-> ##[1:24] quiet4)
      else $error("channel still active after abort");
endmodule // dcc_channel_checker

bind dcc_channel dcc_channel_checker u_chk (.clk(clk), .rst_b(rst_b), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
   .prdata(prdata), .fcAck(fcAck), .arbReq(arbReq), .busReq(busReq), .busWrite(busWrite),
   .busAddr(busAddr), .busSize(busSize), .busAck(busAck), .irq(irq));

/* File: bench/dcc_bus_model.sv */
// internal bus slave model answering each packet access after a set delay
`timescale 1ns/10ps
module dcc_bus_model
(
   // clock and reset
   input  wire logic        clk,
   input  wire logic        rst_b,
   // wait cycles before each answer
   input  wire logic [3:0]  lat,
   // internal bus
   input  wire logic        busReq,
   input  wire logic        busWrite,
   input  wire logic [31:0] busAddr,
   output logic             busAck,
   output logic [31:0]      busRdata
);
   logic [3:0]  waitCnt;
   logic [31:0] logA [8];
   int          nLog;
   // read data toggles outside an answer so stale values never match
   always_ff @(posedge clk)
   begin
      busAck   <= 1'b0;
      busRdata <= ~busRdata;
      if (!rst_b)
      begin
         waitCnt  <= 4'h0;
         nLog     <= 0;
         busRdata <= 32'h0000_0000;
      end
      else if (busReq && !busAck && waitCnt < lat)
         waitCnt <= waitCnt + 4'h1;
      else if (busReq && !busAck)
      begin
         busAck   <= 1'b1;
         busRdata <= busAddr ^ 32'h5A5A_5A5A;
         waitCnt  <= 4'h0;
         nLog     <= nLog + 1;
         if (nLog < 8)
            logA[nLog] <= {busWrite, busAddr[30:0]};
      end
   end
endmodule // dcc_bus_model

/* File: bench/dma_channel_control_bench.sv */
// self-checking bench for the dma channel control block
`timescale 1ns/10ps
module dma_channel_control_bench;
   import dcc_pkg::*;
   typedef struct packed {logic [7:0] a; logic [31:0] d; logic [31:0] e;} dcc_row_t;
   logic        clk, rst_b, psel, penable, pwrite, pready, pslverr;
   logic        fcAck, arbReq, arbLock, arbGrant, busReq, busWrite, busAck, irq;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, busAddr, busWdata, busRdata, rdv, lastW;
   logic        errv = 1'b0;
   logic [15:0] fcReq, fcTerm;
   logic [2:0]  busSize;
   logic [3:0]  lat;
   int          num_errors = 0;
   int          compares = 0;
   int          cyc = 0;
   logic [31:0] expLog [4] = '{32'h0000_0100, 32'h8000_0200, 32'h0000_0104, 32'h8000_0204};
   dcc_row_t    rows [6] = '{
      '{8'h04, 32'h1234_5678, 32'h1234_5678}, '{8'h0C, 32'h8765_4321, 32'h8765_4321},
      '{8'h10, 32'hFEFF_FFFF, 32'h027F_FF05}, '{8'h10, 32'h0000_0000, 32'h0000_0000},
      '{8'h18, 32'h0000_0007, 32'h0000_0007}, '{8'h1C, 32'hFFFF_FFFF, 32'h0000_0000}};

   dcc_channel #(.FC_DEVICES(16)) u_dut (.clk(clk), .rst_b(rst_b), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
      .prdata(prdata), .pslverr(pslverr), .fcReq(fcReq), .fcTerm(fcTerm), .fcAck(fcAck),
      .arbReq(arbReq), .arbLock(arbLock), .arbGrant(arbGrant), .busReq(busReq),
      .busWrite(busWrite), .busAddr(busAddr), .busSize(busSize), .busWdata(busWdata),
      .busAck(busAck), .busRdata(busRdata), .irq(irq));
   dcc_bus_model u_bus (.clk(clk), .rst_b(rst_b), .lat(lat), .busReq(busReq),
      .busWrite(busWrite), .busAddr(busAddr), .busAck(busAck), .busRdata(busRdata));

   // clock, arbiter grant following request, hang limit
   always #12.5 clk = ~clk;
   always @(posedge clk)
   begin
      arbGrant <= arbReq;
      if (busReq && busWrite && busAck)
         lastW <= busWdata;
      cyc <= cyc + 1;
      if (cyc == 20000)
      begin
         num_errors++;
         close_out();
      end
   end

   // one apb transfer held until pready
   task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
      @(posedge clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rdv  = prdata;
      errv = errv | pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      compares++;
      if (g !== e)
      begin
         num_errors++;
         $display("mismatch at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      xfer(a, 1'b1, d);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      xfer(a, 1'b0, 32'h0000_0000);
      chk(rdv & m, e);
   endtask
   task automatic waitHi(ref logic s);
      for (int n = 0; n < 400 && s !== 1'b1; n++)
         @(negedge clk);
      chk({31'h0, s}, 32'h0000_0001);
   endtask
   task automatic close_out();
      $display("errors %0d compares %0d", num_errors, compares);
      if (num_errors == 0 && compares > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   // main sequence
   initial
   begin
      {clk, rst_b, psel, penable, pwrite, paddr, pwdata, fcReq, fcTerm, lat} = '0;
      repeat (16) @(posedge clk);
      rst_b <= 1'b1;
      for (int i = 0; i < 8; i++)
         rd(8'(i * 4), 32'hFFFF_FFFF, 32'h0000_0000);
      foreach (rows[i])
      begin
         wr(rows[i].a, rows[i].d);
         rd(rows[i].a, 32'hFFFF_FFFF, rows[i].e);
      end
      // firmware transfer of two four-byte packets, memory to device
      wr(ACTIVATE_OFS, 32'h0000_0001);
      wr(MEM_START_OFS, 32'h0000_0100);
      wr(MEM_END_OFS, 32'h0000_0108);
      wr(DEV_ADDR_OFS, 32'h0000_0200);
      wr(CONTROL_OFS, 32'h004B_0100);
      wr(CONTROL_OFS, 32'h014B_0100);
      waitHi(irq);
      for (int k = 0; k < 4; k++)
         chk(u_bus.logA[k], expLog[k]);
      chk(lastW, 32'h5A5A_5B5E);
      rd(MEM_START_OFS, 32'hFFFF_FFFF, 32'h0000_0108);
      rd(DEV_ADDR_OFS, 32'hFFFF_FFFF, 32'h0000_0208);
      rd(CONTROL_OFS, 32'hFFFF_FFFF, 32'h004B_0100);
      rd(INT_STAT_OFS, 32'hFFFF_FFFF, 32'h0000_0001);
      rd(INT_STAT_OFS, 32'hFFFF_FFFF, 32'h0000_0000);
      chk({31'h0, irq}, 32'h0000_0000);
      // hardware mode with a slow bus: bypassed, then stopped, then running
      lat <= 4'h5;
      fcReq <= 16'h0001;
      wr(INT_MASK_OFS, 32'h0000_0002);
      wr(MEM_START_OFS, 32'h0000_0300);
      wr(MEM_END_OFS, 32'h0000_0300);
      wr(CONTROL_OFS, 32'h0018_0001);
      repeat (20) @(posedge clk);
      rd(CONTROL_OFS, 32'h0000_0020, 32'h0000_0000);
      wr(CONTROL_OFS, 32'h0010_0000);
      repeat (20) @(posedge clk);
      rd(CONTROL_OFS, 32'h0000_0020, 32'h0000_0000);
      wr(CONTROL_OFS, 32'h0014_0001);
      waitHi(fcAck);
      @(negedge clk);
      waitHi(fcAck);
      rd(CONTROL_OFS, 32'h0000_0020, 32'h0000_0020);
      chk({31'h0, arbLock}, 32'h0000_0001);
      rd(INT_STAT_OFS, 32'hFFFF_FFFF, 32'h0000_0000);
      // abort mid-transfer, then mask and clear its interrupt
      wr(CONTROL_OFS, 32'h0214_0001);
      waitHi(irq);
      chk({31'h0, arbLock}, 32'h0000_0000);
      rd(CONTROL_OFS, 32'h0000_0020, 32'h0000_0000);
      wr(INT_MASK_OFS, 32'h0000_0001);
      chk({31'h0, irq}, 32'h0000_0000);
      rd(INT_STAT_OFS, 32'hFFFF_FFFF, 32'h0000_0002);
      // hardware terminate ends the transfer and raises its own event
      fcTerm <= 16'h0001;
      wr(INT_MASK_OFS, 32'h0000_0004);
      wr(CONTROL_OFS, 32'h0010_0001);
      waitHi(irq);
      @(posedge clk);
      fcReq <= 16'h0000;
      rd(INT_STAT_OFS, 32'h0000_0004, 32'h0000_0004);
      chk({31'h0, errv}, 32'h0000_0000);
      close_out();
   end
endmodule // dma_channel_control_bench
